// file: core/dsprlc_accept.sv
// dsprlc_accept: exception acceptance window around loop entry
// assumes one execute-complete pulse per instruction

`timescale 1ns/1ns

module dsprlc_accept (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   // events
   input  wire logic                       exec_done,
   input  wire logic                       is_pre_loop,
   input  wire logic                       is_first,
   // window
   output dsprlc_pkg::dsprlc_accept_t      accept_q
);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         accept_q <= dsprlc_pkg::ACC_ALL;
      end else if (ce && exec_done) begin
         if (is_pre_loop) begin
            accept_q <= dsprlc_pkg::ACC_BUS;
         end else if (is_first) begin
            accept_q <= dsprlc_pkg::ACC_NONE;
         end else begin
            accept_q <= dsprlc_pkg::ACC_ALL;
         end
      end
   end

endmodule // dsprlc_accept

// file: core/dsprlc_ahb.sv
// dsprlc_ahb: AHB-Lite slave front end, zero wait states, always OKAY
// assumes single word transfers; register file lives in the core

`timescale 1ns/1ns

module dsprlc_ahb (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // AHB-Lite
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   // register access
   output logic             wr_en,
   output logic             rd_en,
   output logic [7:0]       addr
);

   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   logic       take;

   // address phase taken when selected, NONSEQ or SEQ, bus ready
   assign take  = hsel && htrans[1] && hready && ce;
   assign rd_en = take && !hwrite;
   // write data arrive one cycle after the address phase
   assign wr_en = wr_pend_q && ce;
   assign addr  = wr_pend_q ? wr_addr_q : haddr[7:0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (ce) begin
         wr_pend_q <= take && hwrite;
         if (take && hwrite) begin
            wr_addr_q <= haddr[7:0];
         end
      end
   end

endmodule // dsprlc_ahb

// file: core/dsprlc_core.sv
// dsprlc_core: zero-overhead repeat loop control with register bus
// assumes the core reports each executed instruction once at end of
// execute, and asks for a redirect on the fetch address it presents

`timescale 1ns/1ns

module dsprlc_core (
   // clock, reset, enable
   input  wire logic                  CORE_CLK,
   input  wire logic                  RESET_N,
   input  wire logic                  CLK_EN,
   // AHB-Lite slave
   input  wire logic                  HSEL,
   input  wire logic [31:0]           HADDR,
   input  wire logic [1:0]            HTRANS,
   input  wire logic                  HWRITE,
   input  wire logic [2:0]            HSIZE,
   input  wire logic [31:0]           HWDATA,
   input  wire logic                  HREADY,
   output logic [31:0]                HRDATA,
   output logic                       HREADYOUT,
   output logic                       HRESP,
   // fetch side
   input  wire logic [31:0]           FETCH_PC,
   output dsprlc_pkg::dsprlc_fetch_t  FETCH_Q,
   // execute side
   input  wire dsprlc_pkg::dsprlc_exec_t EXEC,
   output logic                       ERR_EXC,
   output logic [31:0]                ERR_PC,
   output logic                       IRQ_OK,
   output logic                       BUSERR_OK
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [31:0]                        start_q;
   logic [31:0]                        end_q;
   logic [dsprlc_pkg::CNT_W-1:0]       count_q;
   logic                               enable_q;
   dsprlc_pkg::dsprlc_state_t          state_q;
   dsprlc_pkg::dsprlc_accept_t         accept_q;
   logic                               err_q;
   logic [31:0]                        push_q;
   logic                               stall_q;
   logic                               stall_done_q;
   logic                               wr_en;
   logic                               rd_en;
   logic [7:0]                         addr;
   logic [31:0]                        rdata;
   logic [31:0]                        body_len;
   logic [31:0]                        slot;
   logic                               in_body;
   logic                               at_end;
   logic                               bad_op;
   logic [31:0]                        push_d;
   logic                               long_unaligned;

   // instructions in the body, ends included
   function automatic logic [31:0] insn_count(input logic [31:0] s,
                                               input logic [31:0] e);
      insn_count = ((e - s) >> 1) + 32'h0000_0001;
   endfunction

   // zero-based slot of pc inside the body
   function automatic logic [31:0] slot_of(input logic [31:0] s,
                                            input logic [31:0] pc);
      slot_of = (pc - s) >> 1;
   endfunction

   assign body_len       = insn_count(start_q, end_q);
   assign slot           = slot_of(start_q, EXEC.pc);
   assign in_body        = (EXEC.pc >= start_q) && (EXEC.pc <= end_q);
   assign at_end         = (FETCH_PC == end_q);
   assign bad_op         = EXEC.valid && EXEC.forbidden && in_body
                           && (state_q == dsprlc_pkg::ST_LOOP);
   assign long_unaligned = (body_len > dsprlc_pkg::SMALL_MAX)
                           && (start_q[1:0] != 2'b00);

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   dsprlc_ahb u_ahb (
      .clk    (CORE_CLK),
      .rst_n  (RESET_N),
      .ce     (CLK_EN),
      .hsel   (HSEL),
      .haddr  (HADDR),
      .htrans (HTRANS),
      .hwrite (HWRITE),
      .hready (HREADY),
      .wr_en  (wr_en),
      .rd_en  (rd_en),
      .addr   (addr)
   );

   // ----------------------------------------------------------------
   // loop address registers
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         start_q <= dsprlc_pkg::RST_ADDR;
         end_q   <= dsprlc_pkg::RST_ADDR;
      end else if (CLK_EN) begin
         if (EXEC.valid && EXEC.set_start) begin
            start_q <= EXEC.pc + EXEC.count_reg;
         end else if (wr_en && addr == dsprlc_pkg::OFS_START) begin
            start_q <= HWDATA;
         end
         if (EXEC.valid && EXEC.set_end) begin
            end_q <= EXEC.pc + EXEC.count_reg;
         end else if (wr_en && addr == dsprlc_pkg::OFS_END) begin
            end_q <= HWDATA;
         end
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         enable_q <= dsprlc_pkg::RST_CTRL[dsprlc_pkg::CTRL_BIT_EN];
      end else if (CLK_EN && wr_en && addr == dsprlc_pkg::OFS_CTRL) begin
         enable_q <= HWDATA[dsprlc_pkg::CTRL_BIT_EN];
      end
   end

   // ----------------------------------------------------------------
   // loop counter and mode
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         count_q <= dsprlc_pkg::RST_COUNT;
         state_q <= dsprlc_pkg::ST_IDLE;
      end else if (CLK_EN) begin
         if (EXEC.valid && EXEC.set_count) begin
            if (EXEC.count_from_reg) begin
               count_q <= EXEC.count_reg[dsprlc_pkg::CNT_W-1:0];
            end else begin
               count_q <= {4'h0, EXEC.count_imm};
            end
            state_q <= dsprlc_pkg::ST_ARMED;
         end else begin
            case (state_q)
               dsprlc_pkg::ST_IDLE: begin
                  state_q <= dsprlc_pkg::ST_IDLE;
               end
               dsprlc_pkg::ST_ARMED: begin
                  if (FETCH_PC == start_q) begin
                     state_q <= dsprlc_pkg::ST_LOOP;
                  end
               end
               dsprlc_pkg::ST_LOOP: begin
                  // branch back keeps count as is
                  if (at_end && !stall_q && !EXEC.branch_back) begin
                     if (count_q >= 12'h002) begin
                        count_q <= count_q - 12'h001;
                     end else begin
                        // one: last pass; zero stays zero
                        count_q <= 12'h000;
                        state_q <= dsprlc_pkg::ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_q <= dsprlc_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // fetch redirect and alignment stall
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         stall_q      <= 1'b0;
         stall_done_q <= 1'b0;
      end else if (CLK_EN) begin
         // one bubble per pass of a long unaligned body that goes round again, then release the redirect
         if (at_end && state_q == dsprlc_pkg::ST_LOOP && enable_q
             && count_q >= 12'h002 && long_unaligned
             && !stall_done_q) begin
            stall_q      <= 1'b1;
            stall_done_q <= 1'b1;
         end else begin
            stall_q <= 1'b0;
            if (!at_end) begin
               stall_done_q <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         FETCH_Q <= '0;
      end else if (CLK_EN) begin
         FETCH_Q.stall  <= at_end && state_q == dsprlc_pkg::ST_LOOP
                           && enable_q && count_q >= 12'h002
                           && long_unaligned && !stall_done_q;
         // count must be two or more to go round again
         // fetch pc has moved past the end by the time the stall shows,
         // so the pending stall itself carries the redirect
         FETCH_Q.redirect <= (at_end && state_q == dsprlc_pkg::ST_LOOP
                           && enable_q && count_q >= 12'h002
                           && !long_unaligned) || stall_q;
         FETCH_Q.target   <= start_q;
      end
   end

   // ----------------------------------------------------------------
   // error exception for forbidden ops in small loops
   // ----------------------------------------------------------------
   always_comb begin
      push_d = EXEC.pc;
      if (count_q >= 12'h002) begin
         if (body_len <= dsprlc_pkg::SHORT_MAX) begin
            push_d = start_q;
         end else if (slot == 32'h0000_0003) begin
            push_d = start_q - dsprlc_pkg::BACK_FOUR;
         end else if (slot == 32'h0000_0004) begin
            push_d = start_q - dsprlc_pkg::BACK_TWO;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         err_q  <= 1'b0;
         push_q <= dsprlc_pkg::RST_ADDR;
      end else if (CLK_EN) begin
         // small loop: only the last three slots are checked
         err_q <= bad_op && (body_len <= dsprlc_pkg::SHORT_MAX
                  || (body_len <= dsprlc_pkg::SMALL_MAX
                      && slot + 32'h0000_0003 >= body_len));
         if (bad_op) begin
            push_q <= push_d;
         end
      end
   end

   assign ERR_EXC = err_q;
   assign ERR_PC  = push_q;

   // ----------------------------------------------------------------
   // exception acceptance window
   // ----------------------------------------------------------------
   dsprlc_accept u_accept (
      .clk         (CORE_CLK),
      .rst_n       (RESET_N),
      .ce          (CLK_EN),
      .exec_done   (EXEC.valid),
      .is_pre_loop (state_q == dsprlc_pkg::ST_ARMED
                    && EXEC.pc + dsprlc_pkg::INSN_BYTES == start_q),
      .is_first    (state_q != dsprlc_pkg::ST_IDLE
                    && EXEC.pc == start_q),
      .accept_q    (accept_q)
   );

   assign IRQ_OK    = (accept_q == dsprlc_pkg::ACC_ALL);
   assign BUSERR_OK = (accept_q != dsprlc_pkg::ACC_NONE);

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   always_comb begin
      if (addr == dsprlc_pkg::OFS_START) begin
         rdata = start_q;
      end else if (addr == dsprlc_pkg::OFS_END) begin
         rdata = end_q;
      end else if (addr == dsprlc_pkg::OFS_COUNT) begin
         rdata = {20'h00000, count_q};
      end else if (addr == dsprlc_pkg::OFS_CTRL) begin
         rdata = {31'h00000000, enable_q};
      end else if (addr == dsprlc_pkg::OFS_STATUS) begin
         rdata = {4'h0, count_q, 11'h000, BUSERR_OK, !IRQ_OK,
                  stall_q, err_q, state_q == dsprlc_pkg::ST_LOOP};
      end else if (addr == dsprlc_pkg::OFS_PUSHPC) begin
         rdata = push_q;
      end else begin
         rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         HRDATA    <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else if (CLK_EN && rd_en) begin
         HRDATA <= rdata;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   cnt_load_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && EXEC.valid && EXEC.set_count && !EXEC.count_from_reg
      |=> count_q == {4'h0, $past(EXEC.count_imm)})
      else $error("immediate count not loaded");
   arm_mode_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && EXEC.valid && EXEC.set_count
      |=> state_q == dsprlc_pkg::ST_ARMED)
      else $error("count load did not arm loop");
   done_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $fell(state_q == dsprlc_pkg::ST_LOOP) && !$past(EXEC.set_count)
      |-> count_q == 12'h000)
      else $error("count not zero after loop");
   no_redir_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && count_q < 12'h002 && !stall_q
      |=> !FETCH_Q.redirect)
      else $error("redirect with count below two");
   redir_tgt_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      FETCH_Q.redirect |-> FETCH_Q.target == start_q)
      else $error("redirect target not loop start");
   cnt_dec_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && at_end && state_q == dsprlc_pkg::ST_LOOP
      && count_q >= 12'h002 && !stall_q && !EXEC.branch_back
      && !(EXEC.valid && EXEC.set_count)
      |=> count_q == $past(count_q) - 12'h001)
      else $error("count not decremented on redirect");
   one_stall_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      FETCH_Q.stall && CLK_EN |=> !FETCH_Q.stall)
      else $error("stall longer than one cycle");
   short_pc_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && bad_op && count_q >= 12'h002
      && body_len <= dsprlc_pkg::SHORT_MAX
      |=> ERR_EXC && ERR_PC == start_q)
      else $error("short loop pushed pc wrong");
   first_blk_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && EXEC.valid && state_q != dsprlc_pkg::ST_IDLE
      && EXEC.pc == start_q |=> !IRQ_OK && !BUSERR_OK)
      else $error("exceptions open after first slot");
   pre_bus_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && EXEC.valid && state_q == dsprlc_pkg::ST_ARMED
      && EXEC.pc + dsprlc_pkg::INSN_BYTES == start_q
      |=> !IRQ_OK && BUSERR_OK)
      else $error("pre-loop window wrong");

   loop_run_c: cover property (@(posedge CORE_CLK) FETCH_Q.redirect);
   stall_c:    cover property (@(posedge CORE_CLK) FETCH_Q.stall);
   err_c:      cover property (@(posedge CORE_CLK) ERR_EXC);

endmodule // dsprlc_core

// file: core/dsprlc_pkg.sv
// dsprlc_pkg: constants, states and carriers of the repeat loop control
// assumes a 32-bit byte address space with 16-bit instructions

package dsprlc_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses on the register bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_START  = 8'h00;
   localparam logic [7:0] OFS_END    = 8'h04;
   localparam logic [7:0] OFS_COUNT  = 8'h08;
   localparam logic [7:0] OFS_CTRL   = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_PUSHPC = 8'h14;

   // ----------------------------------------------------------------
   // field positions and widths
   // ----------------------------------------------------------------
   localparam int          CNT_W        = 12;
   localparam int          IMM_W        = 8;
   localparam int          CTRL_BIT_EN  = 0;
   localparam int          ST_BIT_ACT   = 0;
   localparam int          ST_BIT_ERR   = 1;
   localparam int          ST_BIT_STALL = 2;
   localparam int          ST_BIT_HOLD  = 3;
   localparam int          ST_BIT_BUSOK = 4;
   localparam int          ST_CNT_LSB   = 16;

   // ----------------------------------------------------------------
   // reset values and loop figures
   // ----------------------------------------------------------------
   localparam logic [31:0]      RST_ADDR   = 32'h0000_0000;
   localparam logic [CNT_W-1:0] RST_COUNT  = 12'h000;
   localparam logic [31:0]      RST_CTRL   = 32'h0000_0001;
   localparam logic [31:0]      INSN_BYTES = 32'h0000_0002;
   localparam logic [31:0]      BACK_FOUR  = 32'h0000_0004;
   localparam logic [31:0]      BACK_TWO   = 32'h0000_0002;
   localparam logic [31:0]      SHORT_MAX  = 32'h0000_0003;
   localparam logic [31:0]      SMALL_MAX  = 32'h0000_0004;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_LOOP  = 2'b10
   } dsprlc_state_t;

   typedef enum logic [1:0] {
      ACC_ALL  = 2'b00,
      ACC_BUS  = 2'b01,
      ACC_NONE = 2'b10
   } dsprlc_accept_t;

   // one executed instruction, as seen at the end of its execute stage
   typedef struct packed {
      logic        valid;
      logic [31:0] pc;
      logic        set_start;
      logic        set_end;
      logic        set_count;
      logic        count_from_reg;
      logic [7:0]  count_imm;
      logic [31:0] count_reg;
      logic        forbidden;
      logic        branch_back;
   } dsprlc_exec_t;

   // answer to the fetch unit
   typedef struct packed {
      logic        redirect;
      logic [31:0] target;
      logic        stall;
   } dsprlc_fetch_t;

endpackage : dsprlc_pkg

// file: test/dsprlc_core_tb.sv
// dsprlc_core_tb: register accesses and loop runs with expected values
// assumes the program model dsprlc_prog and a zero-wait slave

`timescale 1ns/1ns

module dsprlc_core_tb;
   logic                      clk = 0, rst_n = 0, go = 0, fr = 0, acc_on = 0;
   logic                      hsel = 0, hwrite = 0, hready, hresp, err;
   logic                      irq_ok, bus_ok, busy;
   logic [1:0]                htrans = 0;
   logic [31:0]               haddr = 0, hwdata = 0, hrdata, fpc, err_pc;
   logic [31:0]               sa = 0, ea = 0, bad = '1, rd, epc;
   logic [11:0]               cnt = 0;
   logic [3:0]                seq;
   logic [12:0]               passes;
   int                        fail_count = 0, check_count = 0, red, stl, errs;
   dsprlc_pkg::dsprlc_fetch_t fq;
   dsprlc_pkg::dsprlc_exec_t  ex;

   initial forever #50 clk = ~clk;

   dsprlc_core i_dsprlc_core (.CORE_CLK(clk), .RESET_N(rst_n),
      .CLK_EN(1'h1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .FETCH_PC(fpc),
      .FETCH_Q(fq), .EXEC(ex), .ERR_EXC(err), .ERR_PC(err_pc),
      .IRQ_OK(irq_ok), .BUSERR_OK(bus_ok));

   dsprlc_prog i_dsprlc_prog (.clk(clk), .rst_n(rst_n), .go(go),
      .start_a(sa), .end_a(ea), .cnt(cnt), .from_reg(fr), .bad_pc(bad),
      .busy(busy), .seq(seq), .passes(passes), .fq(fq), .err(err),
      .pc(fpc), .ex(ex));

   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h not %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wait_for(input logic lvl);
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((lvl ? hready : busy) !== lvl && n < 5000);
      if (n >= 5000) begin
         fail_count++;
         complete_run;
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_for(1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_for(1'h1);
      rd = hrdata;
   endtask

   task automatic run(input logic [31:0] s, e, input logic [11:0] c,
                      input logic r, input logic [31:0] b);
      sa <= s;
      ea <= e;
      cnt <= c;
      fr <= r;
      bad <= b;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      wait_for(1'h0);
   endtask

   task automatic lp(input logic [31:0] s, e, input logic [11:0] c,
                     input logic r, input logic [31:0] p, rr, ss);
      run(s, e, c, r, 32'hffff_ffff);
      check({19'h0, passes}, p);
      check(red, rr);
      check(stl, ss);
      check(errs, 32'h0);
      bus(1'h0, dsprlc_pkg::OFS_COUNT, 32'h0);
      check(rd, 32'h0);
   endtask

   // redirect, stall and exception tallies for the current run
   always @(posedge clk) begin
      if (go) begin
         red = 0;
         stl = 0;
         errs = 0;
      end
      red += fq.redirect;
      stl += fq.stall;
      if (err) begin
         errs++;
         epc = err_pc;
      end
   end

   always @(negedge clk) begin
      if (acc_on && busy && seq == 4'h5 && passes == 13'h0) begin
         if (fpc == sa) check({irq_ok, bus_ok}, 32'h1);
         if (fpc == sa + 2) check({irq_ok, bus_ok}, 32'h0);
         if (fpc == sa + 4) check({irq_ok, bus_ok}, 32'h3);
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      bus(1'h0, dsprlc_pkg::OFS_CTRL, 32'h0);
      check(rd, dsprlc_pkg::RST_CTRL);
      bus(1'h0, dsprlc_pkg::OFS_COUNT, 32'h0);
      check(rd, 32'h0);
      bus(1'h0, 8'h18, 32'h0);
      check(rd, 32'h0);
      bus(1'h1, dsprlc_pkg::OFS_CTRL, 32'h0);
      bus(1'h0, dsprlc_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'h0);
      check(hresp, 32'h0);
      bus(1'h1, dsprlc_pkg::OFS_CTRL, 32'h1);
      lp(32'h100, 32'h104, 12'h0, 1'h0, 1, 0, 0);
      lp(32'h100, 32'h104, 12'h1, 1'h0, 1, 0, 0);
      acc_on = 1'h1;
      lp(32'h100, 32'h104, 12'h2, 1'h0, 2, 1, 0);
      acc_on = 1'h0;
      bus(1'h0, dsprlc_pkg::OFS_END, 32'h0);
      check(rd, 32'h104);
      lp(32'h100, 32'h108, 12'hff, 1'h0, 255, 254, 0);
      lp(32'h100, 32'h104, 12'h12c, 1'h1, 300, 299, 0);
      lp(32'h100, 32'h104, 12'h12c, 1'h0, 44, 43, 0);
      lp(32'h102, 32'h10a, 12'h4, 1'h0, 4, 3, 3);
      run(32'h100, 32'h104, 12'h3, 1'h0, 32'h102);
      check(epc, 32'h100);
      run(32'h100, 32'h104, 12'h1, 1'h0, 32'h102);
      check(epc, 32'h102);
      run(32'h100, 32'h106, 12'h3, 1'h0, 32'h106);
      check(epc, 32'hfc);
      check(errs, 32'h1);
      complete_run;
   end
endmodule // dsprlc_core_tb

// file: test/dsprlc_prog.sv
// dsprlc_prog: program model that sets up and runs one repeat loop
// assumes the core answers fetch one cycle after the end address

`timescale 1ns/1ns

module dsprlc_prog (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // run control
   input  wire logic                     go,
   input  wire logic [31:0]              start_a,
   input  wire logic [31:0]              end_a,
   input  wire logic [11:0]              cnt,
   input  wire logic                     from_reg,
   input  wire logic [31:0]              bad_pc,
   output logic                          busy,
   output logic [3:0]                    seq,
   output logic [12:0]                   passes,
   // core side
   input  wire dsprlc_pkg::dsprlc_fetch_t fq,
   input  wire logic                     err,
   output logic [31:0]                   pc,
   output dsprlc_pkg::dsprlc_exec_t      ex
);
   // ------------------------------------------------------------
   // sequencing: setup ops, one gap op, then the body
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy <= 1'h0;
         seq <= 4'h0;
         passes <= 13'h0;
         pc <= 32'h0;
      end else if (go) begin
         busy <= 1'h1;
         seq <= 4'h1;
         passes <= 13'h0;
         pc <= start_a - 32'h2;
      end else if (busy && seq < 4'h5) begin
         seq <= seq + 4'h1;
         if (seq == 4'h4) pc <= pc + 32'h2;
      end else if (busy) begin
         if (ex.valid && pc == end_a) passes <= passes + 13'h1;
         // an exception ends the program, as a real handler would
         if (err || pc == end_a + 32'h4) busy <= 1'h0;
         else if (fq.redirect) pc <= fq.target;
         else if (!fq.stall) pc <= pc + 32'h2;
      end
   end

   // body holds plain ops only: no setup, pc-relative or branch ops
   always_comb begin
      ex = '0;
      ex.valid = busy && !(seq == 4'h5 && fq.stall);
      ex.pc = pc;
      ex.set_start = seq == 4'h1;
      ex.set_end = seq == 4'h2;
      ex.set_count = seq == 4'h3;
      ex.count_from_reg = from_reg && seq == 4'h3;
      ex.count_imm = cnt[7:0];
      ex.count_reg = seq == 4'h1 ? start_a - pc :
                     seq == 4'h2 ? end_a - pc : {20'h0, cnt};
      ex.forbidden = seq == 4'h5 && pc == bad_pc;
   end
endmodule // dsprlc_prog
